// >>> dv/hfc_checker.sv
// Port checker of the host function code interpreter, bound to its top
`timescale 1ns/1ps
module hfc_checker #(
  parameter int unsigned MSG_TIMEOUT_CYC = 50
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic DL_STROBE,
  input wire logic [7:0] DL_CODE,
  input wire logic MSG_TIMEOUT,
  input wire logic BUSY,
  input wire logic NET_MODE,
  input wire logic TARE_INTERLOCK_EN
);
  int unsigned open_cnt; // Cycles spent away from idle
  // Frame age, so a timeout can be tied to how long the frame stood open
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      open_cnt <= 0;
    end else begin
      open_cnt <= BUSY ? open_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Terminator taken, and a stalled reply byte
  sequence s_cr_taken; RX_VALID && RX_DATA == hfc_pkg::CH_CR; endsequence
  sequence s_stall; TX_VALID && !TX_READY; endsequence
  property p_held; s_stall |=> TX_VALID && $stable(TX_DATA); endproperty
  chk_dl_after_cr: assert property (DL_STROBE |->
    $past(RX_VALID) && $past(RX_DATA) == 8'h0d)
    else $error("download strobe without a terminator just before");
  chk_dl_one_pulse: assert property (DL_STROBE |=> !DL_STROBE)
    else $error("download strobe longer than one cycle");
  chk_dl_code_listed: assert property (DL_STROBE |-> DL_CODE inside {8'h44, 8'h46, 8'h47,
    8'h48, 8'h4b, 8'h4c, 8'h50}) else $error("download accepted for a code not allowed");
  chk_tare_locked: assert property (DL_STROBE && DL_CODE == 8'h44 |->
    !($past(TARE_INTERLOCK_EN) && $past(NET_MODE))) else $error("tare taken while locked");
  chk_tx_held: assert property (p_held)
    else $error("reply byte changed or withdrawn while stalled");
  chk_timeout_ends: assert property (MSG_TIMEOUT |=> !MSG_TIMEOUT && !BUSY)
    else $error("timeout did not close the frame in one pulse");
  chk_timeout_age: assert property (MSG_TIMEOUT |-> open_cnt + 2 >= MSG_TIMEOUT_CYC)
    else $error("frame dropped before its time ran out");
  chk_busy_asked: assert property ($rose(BUSY) |->
    $past(RX_VALID) && $past(RX_DATA) == 8'h02)
    else $error("interpreter went busy without a start byte");
  cover property (s_cr_taken ##1 DL_STROBE);
endmodule
bind host_function_code_interpreter hfc_checker #(.MSG_TIMEOUT_CYC(MSG_TIMEOUT_CYC)) hfc_chk_inst (
  .CORE_CLK, .RESET, .RX_DATA, .RX_VALID, .TX_DATA, .TX_VALID, .TX_READY, .DL_STROBE,
  .DL_CODE, .MSG_TIMEOUT, .BUSY, .NET_MODE, .TARE_INTERLOCK_EN
);

// >>> dv/hfc_host_model.sv
// Polling host model: sends frames and collects the replies
`timescale 1ns/1ps
module hfc_host_model (
  input wire logic clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$]; // Reply bytes taken off the link
  bit slow = 1'b0; // Stall the link two cycles in three
  int unsigned tick = 0; // Cycle count for the stall pattern
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // A byte counts only where valid and ready meet at an edge
  always @(posedge clk) begin
    tick <= tick + 1;
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= !slow || (tick % 3 == 0);
  end
  // One byte a cycle; the host speaks only to ask, never answers
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge clk);
      rx_data <= b[i];
      rx_valid <= 1'b1;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // Stale byte must not look valid
  endtask
endmodule

// >>> dv/host_function_code_interpreter_tb_top.sv
// Self-checking bench of the host function code interpreter
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, (a), (b)); end end
module host_function_code_interpreter_tb_top;
  typedef struct packed {logic [7:0] dir; logic [7:0] code; logic [4:0] n; logic ok;} row_t;
  logic clk, rst, rx_valid, tx_valid, tx_ready, dl_strobe, msg_timeout, busy;
  logic [7:0] rx_data, tx_data, rd_code, dl_code;
  logic [4:0] rd_index, dl_len;
  logic [127:0] dl_data;
  wire logic [7:0] rd_data;
  logic [2:0] dec_pos;
  logic [1:0] inc_size;
  logic net, neg, ovr, mot, kg, pwr, prt, expd, kbd, tlock;
  int num_errors = 0;
  int checked = 0;
  int dl_cnt = 0; // Download strobes seen
  int to_cnt = 0; // Timeout pulses seen
  logic [7:0] all_order[11] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h49, 8'h4a, 8'h46, 8'h47,
    8'h50, 8'h51, 8'h4c};
  // Upload rows, then downloads, then codes sent the wrong way
  row_t rows[27] = '{'{8'h55, 8'h42, 5'h0, 1'b1}, '{8'h55, 8'h43, 5'h0, 1'b1},
    '{8'h55, 8'h44, 5'h0, 1'b1}, '{8'h55, 8'h45, 5'h0, 1'b1}, '{8'h55, 8'h46, 5'h0, 1'b1},
    '{8'h55, 8'h47, 5'h0, 1'b1}, '{8'h55, 8'h49, 5'h0, 1'b1}, '{8'h55, 8'h4a, 5'h0, 1'b1},
    '{8'h55, 8'h4c, 5'h0, 1'b1}, '{8'h55, 8'h50, 5'h0, 1'b1}, '{8'h55, 8'h51, 5'h0, 1'b1},
    '{8'h44, 8'h44, 5'h6, 1'b1}, '{8'h44, 8'h46, 5'h10, 1'b1}, '{8'h44, 8'h47, 5'h9, 1'b1},
    '{8'h44, 8'h48, 5'h0, 1'b1}, '{8'h44, 8'h4b, 5'h1, 1'b1}, '{8'h44, 8'h4c, 5'h7, 1'b1},
    '{8'h44, 8'h50, 5'h3, 1'b1}, '{8'h55, 8'h48, 5'h0, 1'b0}, '{8'h55, 8'h4b, 5'h0, 1'b0},
    '{8'h44, 8'h41, 5'h0, 1'b0}, '{8'h44, 8'h42, 5'h6, 1'b0}, '{8'h44, 8'h43, 5'h6, 1'b0},
    '{8'h44, 8'h45, 5'h6, 1'b0}, '{8'h44, 8'h49, 5'h0, 1'b0}, '{8'h44, 8'h4a, 5'h0, 1'b0},
    '{8'h44, 8'h51, 5'h0, 1'b0}};
  // Field bytes come from outside as code xor index, so order is visible
  assign rd_data = rd_code ^ {3'h0, rd_index};
  hfc_host_model host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  host_function_code_interpreter #(.MSG_TIMEOUT_CYC(50)) host_function_code_interpreter_inst (
    .CORE_CLK(clk), .RESET(rst), .RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .RD_CODE(rd_code), .RD_INDEX(rd_index),
    .RD_DATA(rd_data), .DL_STROBE(dl_strobe), .DL_CODE(dl_code), .DL_LEN(dl_len),
    .DL_DATA(dl_data), .MSG_TIMEOUT(msg_timeout), .BUSY(busy), .DEC_POS(dec_pos),
    .INC_SIZE(inc_size), .NET_MODE(net), .NEG_SIGN(neg), .OVER_CAP(ovr), .IN_MOTION(mot),
    .KG_UNITS(kg), .POWER_UP(pwr), .PRINT_MODE(prt), .EXPAND_X10(expd), .KBD_TARE_KG(kbd),
    .TARE_INTERLOCK_EN(tlock));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse counters
  always @(posedge clk) begin
    if (dl_strobe === 1'b1) dl_cnt <= dl_cnt + 1;
    if (msg_timeout === 1'b1) to_cnt <= to_cnt + 1;
  end
  function automatic int len_of(input logic [7:0] c);
    case (c)
      8'h46, 8'h51: return 16;
      8'h47: return 9;
      8'h4a: return 12;
      8'h4c: return 7;
      8'h50: return 3;
      default: return 6;
    endcase
  endfunction
  // Expected field; status bytes carry even parity in bit 7
  function automatic void add_field(input logic [7:0] c, ref logic [7:0] q[$]);
    logic [6:0] s[3];
    s[0] = {1'b0, 1'b1, inc_size, dec_pos};
    s[1] = {pwr, 1'b1, kg, mot, ovr, neg, net};
    s[2] = {kbd, 1'b1, expd, prt, 3'h0};
    for (int i = 0; i < len_of(c); i++) begin
      if (c == 8'h49 && i < 3) q.push_back({^s[i], s[i]});
      else q.push_back(c ^ i[7:0]);
    end
  endfunction
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Send one frame, wait for quiet, compare reply and download outputs
  task automatic frame(input logic [7:0] a, d, c, input int n, input logic [7:0] b0, bit ok);
    logic [7:0] q[$];
    logic [7:0] e[$];
    int s0;
    int quiet;
    s0 = dl_cnt;
    q = {8'h02, a, d, c};
    for (int i = 0; i < n; i++) q.push_back(i == 0 ? b0 : 8'h30 + 8'(i % 10));
    q.push_back(8'h0d);
    host.got.delete();
    host.send(q);
    quiet = 0;
    for (int k = 0; k < 4000 && quiet < 4; k++) begin
      @(posedge clk);
      quiet = (busy === 1'b0 && tx_valid === 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 4) begin
      num_errors++;
      $display("CHECK FAILED at %0t: reply never ended", $time);
      final_report();
    end
    if (d == 8'h55 && ok) begin
      e = {8'h02, a, 8'h55, c};
      if (c == 8'h41) foreach (all_order[j]) add_field(all_order[j], e);
      else add_field(c, e);
      e.push_back(8'h0d);
    end
    `CHK(host.got.size(), e.size())
    foreach (e[j]) if (j < host.got.size()) `CHK(host.got[j], e[j])
    `CHK(dl_cnt - s0, int'(d == 8'h44 && ok))
    if (d == 8'h44 && ok) begin
      `CHK(dl_code, c)
      `CHK(dl_len, n[4:0])
      if (n > 0) `CHK(dl_data[7:0], b0)
    end
    $display("Test done: addr %h dir %h code %h", a, d, c);
  endtask
  initial begin
    int s0;
    rst = 1'b1;
    {dec_pos, inc_size} = 5'h1d;
    {net, neg, ovr, mot, kg, pwr, prt, expd, kbd, tlock} = 10'h2b4;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({tx_valid, dl_strobe, msg_timeout, busy, dl_code, dl_len}, 17'h0)
    foreach (rows[r]) frame(8'h31, rows[r].dir, rows[r].code, rows[r].n, 8'h30, rows[r].ok);
    frame(8'h35, 8'h55, 8'h42, 0, 8'h30, 1'b0);
    frame(8'h30, 8'h55, 8'h42, 0, 8'h30, 1'b1);
    frame(8'h31, 8'h56, 8'h48, 0, 8'h30, 1'b0);
    frame(8'h31, 8'h44, 8'h4d, 0, 8'h30, 1'b0);
    frame(8'h31, 8'h55, 8'h4e, 0, 8'h30, 1'b0);
    frame(8'h31, 8'h44, 8'h46, 16, 8'h20, 1'b0);
    frame(8'h31, 8'h44, 8'h46, 17, 8'h30, 1'b0);
    @(posedge clk);
    tlock <= 1'b1;
    frame(8'h31, 8'h44, 8'h44, 6, 8'h30, 1'b0);
    @(posedge clk);
    tlock <= 1'b0;
    frame(8'h31, 8'h44, 8'h44, 6, 8'h31, 1'b1);
    s0 = to_cnt;
    host.send({8'h02, 8'h31, 8'h44, 8'h48});
    repeat (60) @(posedge clk);
    `CHK(to_cnt - s0, 1)
    s0 = dl_cnt;
    host.send({8'h0d});
    repeat (5) @(posedge clk);
    `CHK(dl_cnt - s0, 0)
    $display("Test done: frame timeout");
    // Reset in mid-frame must forget the half-received request
    host.send({8'h02, 8'h31, 8'h44});
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({busy, tx_valid, dl_strobe, msg_timeout}, 4'h0)
    s0 = dl_cnt;
    host.send({8'h48, 8'h0d});
    repeat (5) @(posedge clk);
    `CHK(dl_cnt - s0, 0)
    $display("Test done: reset mid-frame");
    host.slow = 1'b1;
    frame(8'h31, 8'h55, 8'h41, 0, 8'h30, 1'b1);
    host.slow = 1'b0;
    final_report();
  end
endmodule

// >>> hw/byte_stream_if.sv
// Valid/ready byte stream between the interpreter and its FIFO
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8);
  logic [W-1:0] data; // Payload
  logic valid; // Source offers data
  logic ready; // Sink takes data
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// >>> hw/hfc_pkg.sv
// Shared constants of the host function code interpreter
// Functional notes
// - Packet: STX, address, direction, code, data, CR
// - 44H download acts silently, 55H upload replies
// - Drop message lacking CR within 200 ms
// - Addresses 0 to 4; never transmit unasked
// - Function code byte is upper-case ASCII letter
// - Fixed fields may lead with spaces or zeros; a time/date download holding any space is refused
// - Code 41H returns all fields in order
// - Code 42H replies displayed weight, six bytes
// - Code 43H replies gross weight, no point
// - Code 45H replies net weight, no point
// - Tare download obeys interlock; upload returns tare
// - Code 46H time/date field is sixteen bytes
// - Code 47H carries nine-digit sequence count
// - Code 48H clears print buffer to spaces
// - Code 51H returns last printed data buffer
// - Code 49H upload only, changes nothing
// - Status A: decimal, increment, fixed bits, parity
// - Status B: net, sign, over, motion, kg, powerup
// - Status C: print, expand, keyboard tare kg
// - Code 4CH setpoint uses seven-byte field
package hfc_pkg;
  // Framing characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] DIR_DOWN = 8'h44;
  localparam logic [7:0] DIR_UP = 8'h55;
  localparam logic [7:0] ADDR_LOW = 8'h30;
  localparam logic [7:0] ADDR_HIGH = 8'h34;
  // Function codes
  localparam logic [7:0] FC_ALL = 8'h41;
  localparam logic [7:0] FC_DISP = 8'h42;
  localparam logic [7:0] FC_GROSS = 8'h43;
  localparam logic [7:0] FC_TARE = 8'h44;
  localparam logic [7:0] FC_NET = 8'h45;
  localparam logic [7:0] FC_TIME = 8'h46;
  localparam logic [7:0] FC_SEQ = 8'h47;
  localparam logic [7:0] FC_PCLR = 8'h48;
  localparam logic [7:0] FC_STAT = 8'h49;
  localparam logic [7:0] FC_SETUP = 8'h4a;
  localparam logic [7:0] FC_CTRL = 8'h4b;
  localparam logic [7:0] FC_SETPT = 8'h4c;
  localparam logic [7:0] FC_IDENT = 8'h50;
  localparam logic [7:0] FC_LAST = 8'h51;
  // Field lengths in bytes
  localparam logic [4:0] LEN_WEIGHT = 5'h06;
  localparam logic [4:0] LEN_TIME = 5'h10;
  localparam logic [4:0] LEN_SEQ = 5'h09;
  localparam logic [4:0] LEN_STAT = 5'h06;
  localparam logic [4:0] LEN_SETUP = 5'h0c;
  localparam logic [4:0] LEN_CTRL = 5'h01;
  localparam logic [4:0] LEN_SETPT = 5'h07;
  localparam logic [4:0] LEN_IDENT = 5'h03;
  localparam logic [4:0] LEN_LAST = 5'h10;
  localparam int FIELD_MAX = 16;
  localparam logic [3:0] ALL_LAST = 4'ha;
  localparam logic [4:0] STAT_LOCAL = 5'h03;
  // Header byte positions of a reply
  localparam logic [1:0] HD_STX = 2'h0;
  localparam logic [1:0] HD_ADDR = 2'h1;
  localparam logic [1:0] HD_DIR = 2'h2;
  localparam logic [1:0] HD_CODE = 2'h3;
  // Message timer
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MSG_TIMEOUT_MS = 200;
  localparam int unsigned MSG_TIMEOUT_CYC = MSG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int TX_FIFO_DEPTH = 16;
  // Parser and reply sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADDR = 4'h1,
    S_DIR = 4'h2,
    S_CODE = 4'h3,
    S_DATA = 4'h4,
    S_HEAD = 4'h5,
    S_FETCH = 4'h6,
    S_PUSH = 4'h7,
    S_TAIL = 4'h8
  } state_t;
endpackage

// >>> hw/host_function_code_interpreter.sv
// Function code interpreter of the polled host serial port
`timescale 1ns/1ps
module host_function_code_interpreter #(
  parameter int unsigned MSG_TIMEOUT_CYC = hfc_pkg::MSG_TIMEOUT_CYC,
  parameter bit PARITY_ODD = 1'b0
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic [7:0] RD_CODE,
  output logic [4:0] RD_INDEX,
  input wire logic [7:0] RD_DATA,
  output logic DL_STROBE,
  output logic [7:0] DL_CODE,
  output logic [4:0] DL_LEN,
  output logic [127:0] DL_DATA,
  output logic MSG_TIMEOUT,
  output logic BUSY,
  input wire logic [2:0] DEC_POS,
  input wire logic [1:0] INC_SIZE,
  input wire logic NET_MODE,
  input wire logic NEG_SIGN,
  input wire logic OVER_CAP,
  input wire logic IN_MOTION,
  input wire logic KG_UNITS,
  input wire logic POWER_UP,
  input wire logic PRINT_MODE,
  input wire logic EXPAND_X10,
  input wire logic KBD_TARE_KG,
  input wire logic TARE_INTERLOCK_EN
);
  initial begin
    if (MSG_TIMEOUT_CYC < 2) $error("MSG_TIMEOUT_CYC too small");
  end

  // Interpreter state outside the timer and FIFO, registered as one word
  typedef struct packed {
    hfc_pkg::state_t st; // Parser or reply phase
    logic [7:0] addr; // Address byte of the request
    logic [7:0] code; // Function code of the request
    logic up; // Request is an upload
    logic [15:0][7:0] field; // Received data field
    logic [4:0] cnt; // Data bytes received
    logic ovf; // Field longer than any code allows
    logic [3:0] ci; // Position in the all-functions list
    logic [4:0] bi; // Byte index in current field
    logic [1:0] hi; // Header byte index
    logic dl_stb; // Download applied pulse
    logic [7:0] dl_code; // Code of applied download
    logic [4:0] dl_len; // Length of applied download
    logic [7:0] rd_code; // Field being fetched
    logic [4:0] rd_idx; // Byte being fetched
    logic tx_v; // Output byte held
    logic [7:0] tx_d; // Output byte
    logic tmo; // Timeout pulse
    logic busy; // Frame open or reply being sent
  } core_t;
  core_t r, n;

  byte_stream_if #(.W(8)) push_s ();
  byte_stream_if #(.W(8)) pop_s ();
  logic tmr_expired;
  logic [7:0] cur_code;
  logic [7:0] push_byte;
  logic frame_open;
  logic has_space;

  // Field length of each function code
  function automatic logic [4:0] len_of(input logic [7:0] c);
    case (c)
      hfc_pkg::FC_DISP, hfc_pkg::FC_GROSS, hfc_pkg::FC_TARE, hfc_pkg::FC_NET:
        len_of = hfc_pkg::LEN_WEIGHT;
      hfc_pkg::FC_TIME: len_of = hfc_pkg::LEN_TIME;
      hfc_pkg::FC_SEQ: len_of = hfc_pkg::LEN_SEQ;
      hfc_pkg::FC_STAT: len_of = hfc_pkg::LEN_STAT;
      hfc_pkg::FC_SETUP: len_of = hfc_pkg::LEN_SETUP;
      hfc_pkg::FC_CTRL: len_of = hfc_pkg::LEN_CTRL;
      hfc_pkg::FC_SETPT: len_of = hfc_pkg::LEN_SETPT;
      hfc_pkg::FC_IDENT: len_of = hfc_pkg::LEN_IDENT;
      hfc_pkg::FC_LAST: len_of = hfc_pkg::LEN_LAST;
      default: len_of = '0;
    endcase
  endfunction

  // Reply order of the all-functions request
  function automatic logic [7:0] all_code(input logic [3:0] i);
    case (i)
      4'h0: all_code = hfc_pkg::FC_DISP;
      4'h1: all_code = hfc_pkg::FC_GROSS;
      4'h2: all_code = hfc_pkg::FC_TARE;
      4'h3: all_code = hfc_pkg::FC_NET;
      4'h4: all_code = hfc_pkg::FC_STAT;
      4'h5: all_code = hfc_pkg::FC_SETUP;
      4'h6: all_code = hfc_pkg::FC_TIME;
      4'h7: all_code = hfc_pkg::FC_SEQ;
      4'h8: all_code = hfc_pkg::FC_IDENT;
      4'h9: all_code = hfc_pkg::FC_LAST;
      default: all_code = hfc_pkg::FC_SETPT;
    endcase
  endfunction

  // Direction check per code; unlisted codes fit neither direction
  function automatic logic dir_ok(input logic [7:0] c, input logic up);
    case (c)
      hfc_pkg::FC_ALL, hfc_pkg::FC_DISP, hfc_pkg::FC_GROSS, hfc_pkg::FC_NET,
      hfc_pkg::FC_STAT, hfc_pkg::FC_SETUP, hfc_pkg::FC_LAST:
        dir_ok = up;
      hfc_pkg::FC_PCLR, hfc_pkg::FC_CTRL:
        dir_ok = !up;
      hfc_pkg::FC_TARE, hfc_pkg::FC_TIME, hfc_pkg::FC_SEQ, hfc_pkg::FC_SETPT,
      hfc_pkg::FC_IDENT:
        dir_ok = 1'b1;
      default: dir_ok = 1'b0;
    endcase
  endfunction

  // Bit 7 carries parity over the seven data bits
  function automatic logic [7:0] with_parity(input logic [6:0] b);
    with_parity = {(^b) ^ PARITY_ODD, b};
  endfunction

  // Locally formatted status bytes A, B and C
  function automatic logic [7:0] stat_byte(input logic [1:0] i);
    case (i)
      2'h0: stat_byte = with_parity({1'b0, 1'b1, INC_SIZE, DEC_POS});
      2'h1: stat_byte = with_parity({POWER_UP, 1'b1, KG_UNITS, IN_MOTION,
                                     OVER_CAP, NEG_SIGN, NET_MODE});
      default: stat_byte = with_parity({KBD_TARE_KG, 1'b1, EXPAND_X10,
                                        PRINT_MODE, 3'h0});
    endcase
  endfunction

  // Field currently being sent back
  assign cur_code = (r.code == hfc_pkg::FC_ALL) ? all_code(r.ci) : r.code;
  assign frame_open = (r.st == hfc_pkg::S_ADDR) || (r.st == hfc_pkg::S_DIR) ||
                      (r.st == hfc_pkg::S_CODE) || (r.st == hfc_pkg::S_DATA);

  // Spaces are refused inside a time/date field
  always_comb begin
    has_space = 1'b0;
    for (int i = 0; i < hfc_pkg::FIELD_MAX; i++) begin
      if (5'(i) < r.cnt && r.field[i] == hfc_pkg::CH_SPACE) begin
        has_space = 1'b1;
      end
    end
  end

  // Byte offered to the reply FIFO in each sending phase
  always_comb begin
    push_byte = hfc_pkg::CH_CR;
    if (r.st == hfc_pkg::S_HEAD) begin
      case (r.hi)
        hfc_pkg::HD_STX: push_byte = hfc_pkg::CH_STX;
        hfc_pkg::HD_ADDR: push_byte = r.addr;
        hfc_pkg::HD_DIR: push_byte = hfc_pkg::DIR_UP;
        default: push_byte = r.code;
      endcase
    end else if (r.st == hfc_pkg::S_PUSH) begin
      if (cur_code == hfc_pkg::FC_STAT && r.bi < hfc_pkg::STAT_LOCAL) begin
        push_byte = stat_byte(r.bi[1:0]);
      end else begin
        push_byte = RD_DATA;
      end
    end
  end
  assign push_s.data = push_byte;
  assign push_s.valid = (r.st == hfc_pkg::S_HEAD) || (r.st == hfc_pkg::S_PUSH) ||
                        (r.st == hfc_pkg::S_TAIL);

  // Parser, dispatcher and reply sequencer
  always_comb begin
    n = r;
    n.dl_stb = 1'b0;
    n.tmo = 1'b0;
    case (r.st)
      hfc_pkg::S_IDLE: begin
        // Anything but a start character is dropped, so a trailing checksum is harmless
        if (RX_VALID && RX_DATA == hfc_pkg::CH_STX) begin
          n.st = hfc_pkg::S_ADDR;
        end
      end
      hfc_pkg::S_ADDR: begin
        if (RX_VALID) begin
          n.addr = RX_DATA;
          if (RX_DATA >= hfc_pkg::ADDR_LOW && RX_DATA <= hfc_pkg::ADDR_HIGH) begin
            n.st = hfc_pkg::S_DIR;
          end else begin
            n.st = hfc_pkg::S_IDLE;
          end
        end
      end
      hfc_pkg::S_DIR: begin
        if (RX_VALID) begin
          n.up = (RX_DATA == hfc_pkg::DIR_UP);
          if (RX_DATA == hfc_pkg::DIR_UP || RX_DATA == hfc_pkg::DIR_DOWN) begin
            n.st = hfc_pkg::S_CODE;
          end else begin
            n.st = hfc_pkg::S_IDLE;
          end
        end
      end
      hfc_pkg::S_CODE: begin
        if (RX_VALID) begin
          n.code = RX_DATA;
          n.cnt = '0;
          n.ovf = 1'b0;
          n.st = hfc_pkg::S_DATA;
        end
      end
      hfc_pkg::S_DATA: begin
        if (RX_VALID && RX_DATA == hfc_pkg::CH_CR) begin
          n.st = hfc_pkg::S_IDLE;
          if (!r.ovf && dir_ok(r.code, r.up)) begin
            if (r.up) begin
              n.st = hfc_pkg::S_HEAD;
              n.hi = '0;
              n.ci = '0;
              n.bi = '0;
            end else if (!(r.code == hfc_pkg::FC_TIME && has_space) &&
                         !(r.code == hfc_pkg::FC_TARE && TARE_INTERLOCK_EN && NET_MODE)) begin
              n.dl_stb = 1'b1;
              n.dl_code = r.code;
              n.dl_len = r.cnt;
            end
          end
        end else if (RX_VALID) begin
          // Padding is stored as received; spaces and zeros are both legal, but spaces later refuse a time/date download
          if (r.cnt == 5'(hfc_pkg::FIELD_MAX)) begin
            n.ovf = 1'b1;
          end else begin
            n.field[r.cnt[3:0]] = RX_DATA;
            n.cnt = r.cnt + 1'b1;
          end
        end
      end
      hfc_pkg::S_HEAD: begin
        if (push_s.ready) begin
          n.hi = r.hi + 1'b1;
          if (r.hi == hfc_pkg::HD_CODE) begin
            n.st = (len_of(cur_code) == '0) ? hfc_pkg::S_TAIL : hfc_pkg::S_FETCH;
          end
        end
      end
      hfc_pkg::S_FETCH: begin
        n.rd_code = cur_code;
        n.rd_idx = r.bi;
        n.st = hfc_pkg::S_PUSH;
      end
      hfc_pkg::S_PUSH: begin
        if (push_s.ready) begin
          n.bi = r.bi + 1'b1;
          n.st = hfc_pkg::S_FETCH;
          if (r.bi == len_of(cur_code) - 1'b1) begin
            n.bi = '0;
            if (r.code == hfc_pkg::FC_ALL && r.ci != hfc_pkg::ALL_LAST) begin
              n.ci = r.ci + 1'b1;
            end else begin
              n.st = hfc_pkg::S_TAIL;
            end
          end
        end
      end
      hfc_pkg::S_TAIL: begin
        if (push_s.ready) begin
          n.st = hfc_pkg::S_IDLE;
        end
      end
      default: n.st = hfc_pkg::S_IDLE;
    endcase
    // A new start character after the address resynchronises a half-received frame
    if (frame_open && r.st != hfc_pkg::S_ADDR && RX_VALID && RX_DATA == hfc_pkg::CH_STX) begin
      n.st = hfc_pkg::S_ADDR;
    end
    // Timer expiry throws the open frame away
    if (frame_open && tmr_expired) begin
      n.st = hfc_pkg::S_IDLE;
      n.tmo = 1'b1;
    end
    // Busy is registered so the port comes straight from a flop
    n.busy = (n.st != hfc_pkg::S_IDLE);
    // Output register reloads when it holds no byte or when the link has taken the held byte
    if (!r.tx_v || TX_READY) begin
      n.tx_v = pop_s.valid;
      n.tx_d = pop_s.valid ? pop_s.data : r.tx_d;
    end
  end
  assign pop_s.ready = !r.tx_v || TX_READY;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Frame timer restarts on every start character, so a resynchronised frame gets its full time
  msg_timer #(.LIMIT(MSG_TIMEOUT_CYC)) u_timer (
    .clk(CORE_CLK),
    .rst(RESET),
    .start(RX_VALID && RX_DATA == hfc_pkg::CH_STX && (r.st == hfc_pkg::S_IDLE || frame_open)),
    .run(frame_open),
    .expired(tmr_expired)
  );

  // Reply bytes queue here; a stalled link holds the sequencer back
  stream_fifo #(.W(8), .DEPTH(hfc_pkg::TX_FIFO_DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .rst(RESET),
    .fill(push_s),
    .drain(pop_s)
  );

  // All outputs come from registers
  assign TX_DATA = r.tx_d;
  assign TX_VALID = r.tx_v;
  assign RD_CODE = r.rd_code;
  assign RD_INDEX = r.rd_idx;
  assign DL_STROBE = r.dl_stb;
  assign DL_CODE = r.dl_code;
  assign DL_LEN = r.dl_len;
  assign DL_DATA = r.field;
  assign MSG_TIMEOUT = r.tmo;
  assign BUSY = r.busy;
endmodule

// >>> hw/msg_timer.sv
// Message timer that expires a frame left open too long
`timescale 1ns/1ps
module msg_timer #(
  parameter int unsigned LIMIT = hfc_pkg::MSG_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic run,
  output logic expired
);
  localparam int CW = $clog2(LIMIT + 1);
  initial begin
    if (LIMIT < 2) $error("msg_timer LIMIT too small");
  end
  typedef struct packed {
    logic [CW-1:0] cnt; // Cycles since frame start
    logic expired; // One-cycle expiry pulse
  } tmr_t;
  tmr_t r, n;
  // Count while a frame is open; restart on every start character
  always_comb begin
    n = r;
    n.expired = 1'b0;
    if (start) begin
      n.cnt = '0;
    end else if (run) begin
      if (r.cnt == CW'(LIMIT - 1)) begin
        n.expired = 1'b1;
        n.cnt = '0;
      end else begin
        n.cnt = r.cnt + 1'b1;
      end
    end else begin
      n.cnt = '0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign expired = r.expired;
endmodule

// >>> hw/stream_fifo.sv
// Flip-flop FIFO between two valid/ready byte streams
`timescale 1ns/1ps
module stream_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  byte_stream_if.snk fill,
  byte_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("stream_fifo DEPTH must be a power of two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // Storage
    logic [AW-1:0] wp; // Write index
    logic [AW-1:0] rp; // Read index
    logic [AW:0] cnt; // Words held
  } fifo_t;
  fifo_t r, n;
  logic wr, rd;
  // Full and empty come straight from the word count
  assign fill.ready = (r.cnt != (AW+1)'(DEPTH));
  assign drain.valid = (r.cnt != '0);
  assign drain.data = r.mem[r.rp];
  assign wr = fill.valid && fill.ready;
  assign rd = drain.valid && drain.ready;
  // Pointer and count update
  always_comb begin
    n = r;
    if (wr) begin
      n.mem[r.wp] = fill.data;
      n.wp = r.wp + 1'b1;
    end
    if (rd) begin
      n.rp = r.rp + 1'b1;
    end
    if (wr && !rd) begin
      n.cnt = r.cnt + 1'b1;
    end else if (rd && !wr) begin
      n.cnt = r.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule
